// [plrc_pkg.sv]
// Package for the power loss restart control block.
// Assumes a 100 MHz control clock; the run wait and the tenth-second tick are converted to cycle counts here.
package plrc_pkg;
   // Restart mode codes
   localparam logic [2:0] MODE_TRIP_NOW = 3'h0;
   localparam logic [2:0] MODE_TRIP_AFTER = 3'h1;
   localparam logic [2:0] MODE_RIDE_THROUGH = 3'h3;
   localparam logic [2:0] MODE_SAVED_FREQ = 3'h4;
   localparam logic [2:0] MODE_START_FREQ = 3'h5;
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int RUN_WAIT_MS = 2000;
   localparam int RUN_WAIT_CYC = RUN_WAIT_MS * CLK_MHZ * 1000;
   localparam int TENTH_S_CYC = CLK_MHZ * 100000;
   localparam int FREQ_W = 16;
   localparam int TIME_W = 9;
   localparam logic [FREQ_W-1:0] RIDE_STEP = 16'h0001;
   // Sequencer states, one-hot
   typedef enum logic [5:0] {
      PLRC_RUN = 6'h01,
      PLRC_RIDE = 6'h02,
      PLRC_OUTAGE = 6'h04,
      PLRC_READY = 6'h08,
      PLRC_TRIPPED = 6'h10,
      PLRC_IDLE = 6'h20
   } plrc_state_t;
   // Drive command out to the output stage
   typedef struct packed {
      logic enable;
      logic [FREQ_W-1:0] freq;
   } plrc_drive_t;
endpackage

// [plrc_top.sv]
// Restart sequencer deciding output stage action on DC link sag.
// Assumes monitor comparator inputs synchronous to REF_CLK; times in 0.1 s units.
// Behaviour
// - Mode 0 cuts output and raises undervoltage alarm at once on undervoltage.
// - Mode 1 cuts output on undervoltage without raising the alarm.
// - Mode 1 raises the alarm once supply returns and keeps the output off.
// - Mode 3 enters ride-through when the link falls below the ride-through level.
// - During ride-through the output frequency is lowered to regenerate energy.
// - Mode 3 stores the frequency and cuts output on undervoltage in ride-through.
// - Mode 4 stores the frequency and cuts output on undervoltage.
// - Modes 3 and 4 resume from the stored frequency when power and run return.
// - Mode 5 restarts from the starting frequency setting.
// - Modes 3, 4 and 5 restart by themselves on recovery given a run command.
// - After recovery the block waits two seconds for a run command, else cancels.
// - An outage longer than the allowable outage time becomes a normal start.
// - Restart is held off until the wait time since the failure has elapsed.
// - A coast stop during the outage abandons restart for a normal start.
`timescale 1ns/10ps
`default_nettype none
module plrc_top #(
   parameter int RUN_WAIT = plrc_pkg::RUN_WAIT_CYC,
   parameter int TENTH_S = plrc_pkg::TENTH_S_CYC
) (
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic [2:0] RESTART_MODE_SELECT,
   input wire logic [plrc_pkg::FREQ_W-1:0] STARTING_FREQUENCY_SETTING,
   input wire logic [plrc_pkg::FREQ_W-1:0] REF_FREQ,
   input wire logic [plrc_pkg::TIME_W-1:0] ALLOWABLE_OUTAGE_TIME,
   input wire logic [plrc_pkg::TIME_W-1:0] RESTART_WAIT_TIME,
   input wire logic DC_UNDERVOLT,
   input wire logic DC_BELOW_RIDE,
   input wire logic RUN_CMD,
   input wire logic COAST_STOP_COMMAND,
   output var plrc_pkg::plrc_drive_t DRIVE,
   output logic UV_ALARM,
   output logic RESTARTING
);
   plrc_pkg::plrc_state_t state, next_state;
   plrc_pkg::plrc_drive_t next_drive;
   logic [plrc_pkg::FREQ_W-1:0] saved_freq, next_saved_freq;
   logic [31:0] sub_cnt, next_sub_cnt, wait_cnt, next_wait_cnt;
   logic [plrc_pkg::TIME_W-1:0] tenths, next_tenths;
   logic next_uv_alarm, next_restarting, use_saved, next_use_saved;
   logic [2:0] mode;

   // Reserved codes fold onto immediate trip
   function automatic logic [2:0] plrc_fold(input logic [2:0] m);
      case (m)
         plrc_pkg::MODE_TRIP_AFTER, plrc_pkg::MODE_RIDE_THROUGH,
         plrc_pkg::MODE_SAVED_FREQ, plrc_pkg::MODE_START_FREQ: plrc_fold = m;
         default: plrc_fold = plrc_pkg::MODE_TRIP_NOW;
      endcase
   endfunction

   assign mode = plrc_fold(RESTART_MODE_SELECT);

   // Sequencer next state; elapsed outage counted in tenths of a second
   always_comb begin
      next_state = state;
      next_drive = DRIVE;
      next_saved_freq = saved_freq;
      next_uv_alarm = UV_ALARM;
      next_restarting = 1'b0;
      next_use_saved = use_saved;
      next_sub_cnt = 32'h0;
      next_tenths = tenths;
      next_wait_cnt = 32'h0;
      if (state == plrc_pkg::PLRC_OUTAGE || state == plrc_pkg::PLRC_READY) begin
         if (sub_cnt >= 32'(TENTH_S - 1)) begin
            if (tenths != {plrc_pkg::TIME_W{1'b1}}) begin
               next_tenths = tenths + 9'h001;
            end
         end else begin
            next_sub_cnt = sub_cnt + 32'h1;
         end
      end
      case (state)
         plrc_pkg::PLRC_IDLE: begin
            // Normal start from the live reference frequency REF_FREQ
            next_drive.enable = 1'b0;
            if (RUN_CMD && !DC_UNDERVOLT && !UV_ALARM) begin
               next_drive.enable = 1'b1;
               next_drive.freq = REF_FREQ;
               next_state = plrc_pkg::PLRC_RUN;
            end
            if (!RUN_CMD) begin
               next_uv_alarm = 1'b0;
            end
         end
         plrc_pkg::PLRC_RUN: begin
            next_drive.freq = REF_FREQ;
            if (!RUN_CMD) begin
               next_drive.enable = 1'b0;
               next_state = plrc_pkg::PLRC_IDLE;
            end else if (mode == plrc_pkg::MODE_RIDE_THROUGH && DC_BELOW_RIDE) begin
               next_state = plrc_pkg::PLRC_RIDE;
            end else if (DC_UNDERVOLT) begin
               next_drive.enable = 1'b0;
               next_saved_freq = DRIVE.freq;
               next_tenths = 9'h000;
               // Mode 3 lands here only if undervolt comes without below-ride; both at once go to ride
               next_use_saved = (mode == plrc_pkg::MODE_SAVED_FREQ)
                  || (mode == plrc_pkg::MODE_RIDE_THROUGH);
               if (mode == plrc_pkg::MODE_TRIP_NOW) begin
                  next_uv_alarm = 1'b1;
                  next_state = plrc_pkg::PLRC_TRIPPED;
               end else begin
                  next_state = plrc_pkg::PLRC_OUTAGE;
               end
            end
         end
         plrc_pkg::PLRC_RIDE: begin
            // Slowing the motor pushes inertia energy into the link
            if (DRIVE.freq > plrc_pkg::RIDE_STEP) begin
               next_drive.freq = DRIVE.freq - plrc_pkg::RIDE_STEP;
            end
            if (DC_UNDERVOLT) begin
               next_drive.enable = 1'b0;
               next_saved_freq = DRIVE.freq;
               next_use_saved = 1'b1;
               next_tenths = 9'h000;
               next_state = plrc_pkg::PLRC_OUTAGE;
            end else if (!DC_BELOW_RIDE) begin
               next_state = plrc_pkg::PLRC_RUN;
            end
         end
         plrc_pkg::PLRC_OUTAGE: begin
            if (COAST_STOP_COMMAND) begin
               next_state = plrc_pkg::PLRC_IDLE;
            end else if (tenths > ALLOWABLE_OUTAGE_TIME) begin
               next_state = plrc_pkg::PLRC_IDLE;
            end else if (!DC_UNDERVOLT) begin
               if (mode == plrc_pkg::MODE_TRIP_AFTER) begin
                  next_uv_alarm = 1'b1;
                  next_state = plrc_pkg::PLRC_TRIPPED;
               end else begin
                  next_state = plrc_pkg::PLRC_READY;
               end
            end
         end
         plrc_pkg::PLRC_READY: begin
            next_wait_cnt = wait_cnt + 32'h1;
            if (DC_UNDERVOLT) begin
               next_state = plrc_pkg::PLRC_OUTAGE;
            end else if (COAST_STOP_COMMAND || tenths > ALLOWABLE_OUTAGE_TIME) begin
               next_state = plrc_pkg::PLRC_IDLE;
            end else if (wait_cnt >= 32'(RUN_WAIT - 1) && !RUN_CMD) begin
               next_state = plrc_pkg::PLRC_IDLE;
            end else if (RUN_CMD && tenths >= RESTART_WAIT_TIME) begin
               // Automatic restart, run command and wait time elapsed
               next_drive.enable = 1'b1;
               next_drive.freq = use_saved ? saved_freq
                  : STARTING_FREQUENCY_SETTING;
               next_restarting = 1'b1;
               next_state = plrc_pkg::PLRC_RUN;
            end else if (wait_cnt >= 32'(RUN_WAIT - 1)) begin
               next_wait_cnt = wait_cnt; // Run held; only the wait time blocks
            end
         end
         plrc_pkg::PLRC_TRIPPED: begin
            // Alarm stays until run is released with good supply
            next_drive.enable = 1'b0;
            if (!RUN_CMD && !DC_UNDERVOLT) begin
               next_uv_alarm = 1'b0;
               next_state = plrc_pkg::PLRC_IDLE;
            end
         end
         default: begin
            next_drive.enable = 1'b0;
            next_state = plrc_pkg::PLRC_IDLE;
         end
      endcase
   end

   // Registers only
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state <= plrc_pkg::PLRC_IDLE;
         DRIVE <= '0;
         saved_freq <= 16'h0000;
         UV_ALARM <= 1'b0;
         RESTARTING <= 1'b0;
         use_saved <= 1'b0;
         sub_cnt <= 32'h0;
         tenths <= 9'h000;
         wait_cnt <= 32'h0;
      end else begin
         state <= next_state;
         DRIVE <= next_drive;
         saved_freq <= next_saved_freq;
         UV_ALARM <= next_uv_alarm;
         RESTARTING <= next_restarting;
         use_saved <= next_use_saved;
         sub_cnt <= next_sub_cnt;
         tenths <= next_tenths;
         wait_cnt <= next_wait_cnt;
      end
   end

   chk_trip_now_alarm: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      state == plrc_pkg::PLRC_RUN && RUN_CMD && DC_UNDERVOLT && mode == 3'h0
      |=> UV_ALARM && !DRIVE.enable) else $error("mode 0 trip missed");
   chk_trip_after_quiet: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      state == plrc_pkg::PLRC_RUN && RUN_CMD && DC_UNDERVOLT && mode == 3'h1 && !UV_ALARM
      |=> !UV_ALARM && !DRIVE.enable) else $error("mode 1 alarm early");
   chk_trip_after_alarm: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      state == plrc_pkg::PLRC_OUTAGE && mode == 3'h1 && !DC_UNDERVOLT && !COAST_STOP_COMMAND
      && tenths <= ALLOWABLE_OUTAGE_TIME |=> UV_ALARM && !DRIVE.enable)
      else $error("mode 1 alarm missing");
   chk_ride_entry: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      state == plrc_pkg::PLRC_RUN && RUN_CMD && DC_BELOW_RIDE && mode == 3'h3
      |=> state == plrc_pkg::PLRC_RIDE) else $error("ride entry missed");
   chk_ride_slows: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      state == plrc_pkg::PLRC_RIDE && DRIVE.freq > 16'h0001
      |=> DRIVE.freq == $past(DRIVE.freq) - 16'h0001) else $error("ride not slowing");
   chk_ride_save: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      state == plrc_pkg::PLRC_RIDE && DC_UNDERVOLT
      |=> saved_freq == $past(DRIVE.freq) && !DRIVE.enable) else $error("ride save");
   chk_saved_resume: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      $rose(RESTARTING) && use_saved |-> DRIVE.freq == saved_freq && DRIVE.enable)
      else $error("resume freq wrong");
   chk_start_resume: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      state == plrc_pkg::PLRC_READY && !use_saved ##1 RESTARTING
      |-> DRIVE.freq == $past(STARTING_FREQUENCY_SETTING)) else $error("start freq");
   chk_wait_hold: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      RESTARTING |-> $past(tenths) >= $past(RESTART_WAIT_TIME))
      else $error("restart before wait");
   chk_coast_abandon: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      state == plrc_pkg::PLRC_OUTAGE && COAST_STOP_COMMAND
      |=> state == plrc_pkg::PLRC_IDLE) else $error("coast not honoured");
endmodule
`default_nettype wire

// [plrc_supply_model.sv]
// Mains and DC link monitor model for the restart sequencer bench.
// Assumes the bench sets the supply level on falling clock edges.
`timescale 1ns/10ps
`default_nettype none
module plrc_supply_model (
   input wire logic [1:0] level,
   output logic dc_undervolt,
   output logic dc_below_ride
);
   // Undervolt lies under the ride level, so it always implies below-ride
   assign dc_below_ride = (level != 2'h0);
   assign dc_undervolt = (level == 2'h2);
endmodule
`default_nettype wire

// [plrc_top_tb.sv]
// Self-checking bench for the power loss restart sequencer.
// Assumes short timing parameters: 5 cycles a tenth, 50 cycles run wait.
`timescale 1ns/10ps
`default_nettype none
module plrc_top_tb;
   logic clk = 1'b0, rst_b = 1'b0, run = 1'b0, coast = 1'b0;
   logic [2:0] mode = 3'h0;
   logic [15:0] start_f = 16'h0000, ref_f = 16'h0000, f0;
   logic [8:0] allow = 9'h004, waitt = 9'h002;
   logic [1:0] level = 2'h0;
   logic dcu, dcr, uv, restarting;
   plrc_pkg::plrc_drive_t drive;
   int seed = 32'h1f99ae9d, fails = 0, checks_done = 0, ncyc = 0, tf;
   int trip[5] = '{0, 1, 2, 6, 7};
   plrc_top #(.RUN_WAIT(50), .TENTH_S(5)) dut (.REF_CLK(clk), .RST_B(rst_b),
      .RESTART_MODE_SELECT(mode), .STARTING_FREQUENCY_SETTING(start_f), .REF_FREQ(ref_f),
      .ALLOWABLE_OUTAGE_TIME(allow), .RESTART_WAIT_TIME(waitt), .DC_UNDERVOLT(dcu),
      .DC_BELOW_RIDE(dcr), .RUN_CMD(run), .COAST_STOP_COMMAND(coast), .DRIVE(drive),
      .UV_ALARM(uv), .RESTARTING(restarting));
   plrc_supply_model model (.level(level), .dc_undervolt(dcu), .dc_below_ride(dcr));
   // Free-running clock and a cycle count for the hold-off check
   always #5 clk = ~clk;
   always @(posedge clk) ncyc <= ncyc + 1;
   task automatic summarize();
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         fails++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Stop, then start running in a mode from a fresh random reference
   task automatic start_run(input logic [2:0] m);
      run = 1'b0;
      coast = 1'b0;
      level = 2'h0;
      cyc(3);
      mode = m;
      ref_f = $random(seed) | 16'h8000;
      run = 1'b1;
      cyc(3);
      chk(drive.enable === 1'b1 && drive.freq === ref_f, "run not started");
   endtask
   // Bounded wait for the restart pulse, then frequency within tolerance
   task automatic expect_auto(input logic [15:0] f, input logic [15:0] tol);
      int i;
      logic ok_f;
      for (i = 0; i < 400 && restarting !== 1'b1; i++) cyc(1);
      chk(restarting === 1'b1, "no automatic restart");
      if (i == 400) begin
         summarize();
      end else begin
         chk(ncyc - tf >= waitt * 5, "restart before wait time");
         // Difference form avoids a wrap of the 16-bit sum near full scale
         ok_f = drive.freq <= f && f - drive.freq <= tol;
         chk(drive.enable === 1'b1 && ok_f, "restart frequency wrong");
      end
   endtask
   // A normal start: no restart pulse and the live reference is followed
   task automatic expect_normal(input logic [15:0] f);
      logic seen;
      seen = 1'b0;
      repeat (12) begin
         cyc(1);
         seen = seen | (restarting !== 1'b0);
      end
      chk(!seen && drive.enable === 1'b1 && drive.freq === f, "not a normal start");
   endtask
   initial begin
      cyc(12);
      rst_b = 1'b1;
      // Trip modes; reserved codes must behave as immediate trip
      foreach (trip[k]) begin
         start_run(trip[k]);
         level = 2'h2;
         cyc(3);
         chk(!drive.enable && uv === (trip[k] != 1), "trip");
         level = 2'h0;
         cyc(3);
         chk(drive.enable === 1'b0 && uv === 1'b1, "alarm after recovery");
         run = 1'b0;
         cyc(3);
         chk(uv === 1'b0, "alarm not cleared");
      end
      $display("test trip modes done");
      // Saved and starting frequency restarts; reference moves during outage
      for (int m = 4; m < 6; m++) begin
         start_run(m);
         start_f = $random(seed);
         f0 = ref_f;
         level = 2'h2;
         tf = ncyc;
         cyc(3);
         chk(drive.enable === 1'b0 && uv === 1'b0, "output not cut");
         ref_f = ~ref_f;
         level = 2'h0;
         expect_auto(m == 4 ? f0 : start_f, 16'h0000);
      end
      $display("test restart modes done");
      // Ride-through lowers frequency a step a cycle, then saves it
      start_run(3);
      f0 = ref_f;
      level = 2'h1;
      cyc(2);
      start_f = drive.freq;
      cyc(1);
      chk(start_f < f0 && drive.freq === start_f - plrc_pkg::RIDE_STEP, "ride");
      level = 2'h2;
      tf = ncyc;
      cyc(3);
      chk(drive.enable === 1'b0, "ride output not cut");
      level = 2'h0;
      expect_auto(f0 - 16'h0001, 16'h0004);
      $display("test ride-through done");
      // Outage longer than allowed gives a normal start
      start_run(4);
      level = 2'h2;
      cyc(allow * 5 + 20);
      ref_f = $random(seed);
      level = 2'h0;
      expect_normal(ref_f);
      // Coast stop during the outage abandons restart
      start_run(4);
      level = 2'h2;
      cyc(2);
      coast = 1'b1;
      cyc(2);
      coast = 1'b0;
      ref_f = $random(seed);
      level = 2'h0;
      expect_normal(ref_f);
      // Run command missing beyond the run wait cancels restart
      allow = 9'h0C8; // Long outage limit, so only the run wait can cancel
      start_run(4);
      level = 2'h2;
      cyc(2);
      run = 1'b0;
      level = 2'h0;
      cyc(70);
      chk(!drive.enable && restarting === 1'b0, "started without run");
      ref_f = $random(seed);
      run = 1'b1;
      expect_normal(ref_f);
      $display("test normal starts done");
      summarize();
   end
endmodule
`default_nettype wire
